/* hw/arrs_pkg.sv */
// Constants and types of the repeat-ring conversion sequencer
// Notes on behaviour
// R01 - While running, the selected input is converted back to back at 8- or 10-bit resolution.
// R02 - Exactly one input is chosen, one of twelve analog pins by group and channel, or the reference.
// R03 - Conversion starts on a software start, a timer event or an external trigger.
// R04 - Conversion goes on until software writes 0 to the start bit, and never stops by itself.
// R05 - Results go to result registers 0 to 7 in rotation, the ninth wrapping back to register 0.
// R06 - The interrupt request pulses when a result is written into result register 7.
// R07 - Software reads all eight result registers to collect the results.
// R08 - Software sets standby release and waits a cycle before setting start, never both at once.
// R09 - Software does not clear standby release while converting.
// R10 - The rotation and the interrupt every eighth result go on for as long as conversion runs.
`default_nettype none
package arrs_pkg;
    // Register byte addresses
    localparam logic [11:0] ARRS_CTRL_A_OFS  = 12'h000;
    localparam logic [11:0] ARRS_CTRL_B_OFS  = 12'h004;
    localparam logic [11:0] ARRS_INSEL_OFS   = 12'h008;
    localparam logic [11:0] ARRS_STATUS_OFS  = 12'h00C;
    localparam logic [11:0] ARRS_RESULT_OFS  = 12'h020;
    localparam logic [11:0] ARRS_RESULT_END  = 12'h03C;
    // Control A fields: start bit, trigger source
    localparam int ARRS_START_BIT = 0;
    localparam int ARRS_TRIG_LSB  = 1;
    // Control B fields: standby release, extended select, resolution
    localparam int ARRS_STBY_BIT  = 0;
    localparam int ARRS_EXT_BIT   = 1;
    localparam int ARRS_RES10_BIT = 2;
    // Input select fields
    localparam int ARRS_CH_LSB  = 0;
    localparam int ARRS_GRP_LSB = 4;
    // Trigger sources
    typedef enum logic [1:0] {
        ARRS_TRIG_SW    = 2'b00,
        ARRS_TRIG_TIMER = 2'b01,
        ARRS_TRIG_EXT   = 2'b10
    } arrs_trig_t;
    // Sequencer states
    typedef enum logic [1:0] {
        ARRS_IDLE = 2'b00,
        ARRS_ARM  = 2'b01,
        ARRS_CONV = 2'b10
    } arrs_state_t;
    localparam int          ARRS_NUM_RES   = 8;
    localparam logic [2:0]  ARRS_LAST_SLOT = 3'h7;
    localparam logic [3:0]  ARRS_REF_SEL   = 4'hC;
    localparam logic [31:0] ARRS_ZERO      = 32'h0000_0000;
endpackage
`default_nettype wire

/* hw/arrs_seq.sv */
// Repeat-ring conversion sequencer with APB register slave
`default_nettype none
module arrs_seq (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Trigger sources
    input  wire logic        timer_trigger_source,
    input  wire logic        ext_trigger_pin,
    // Conversion core
    output logic             conv_start,
    output logic      [3:0]  input_sel,
    output logic             conv_res10,
    output logic             core_enable,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_result,
    // Interrupt request
    output logic             conv_irq
);
    import arrs_pkg::*;

    typedef struct packed {
        arrs_state_t state;
        logic        start;
        arrs_trig_t  trig;
        logic        stby;
        logic        ext;
        logic        res10;
        logic [2:0]  chan;
        logic [1:0]  grp;
        logic [2:0]  slot;
        logic [ARRS_NUM_RES-1:0][9:0] res; // Eight result slots, packed
        logic        irq;
        logic [31:0] rdata;
        logic        err;
        logic [1:0]  ext_s;
        logic        ext_prev;
    } arrs_st_t;

    arrs_st_t s_reg, s_next;
    logic     apb_wr, apb_rd, hit, trig_evt, ext_rise;
    logic [3:0] sel;

    // Result-register address test
    function automatic logic is_result(input logic [11:0] a);
        return a >= ARRS_RESULT_OFS && a <= ARRS_RESULT_END && a[1:0] == 2'b00;
    endfunction

    // Input choice: reference, or group and channel to one of twelve pins
    always_comb begin
        if (s_reg.ext)
            sel = ARRS_REF_SEL; // R02
        else
            sel = 4'({s_reg.grp, 2'b00}) + 4'({1'b0, s_reg.chan}); // R02
    end

    // Bus decode and trigger qualification
    assign apb_wr   = psel && penable && pwrite;
    assign apb_rd   = psel && !penable && !pwrite;
    assign hit      = paddr == ARRS_CTRL_A_OFS || paddr == ARRS_CTRL_B_OFS
                   || paddr == ARRS_INSEL_OFS || paddr == ARRS_STATUS_OFS || is_result(paddr);
    assign ext_rise = s_reg.ext_s[1] && !s_reg.ext_prev;
    always_comb begin
        case (s_reg.trig)
            ARRS_TRIG_SW:    trig_evt = 1'b1; // R03
            ARRS_TRIG_TIMER: trig_evt = timer_trigger_source; // R03
            ARRS_TRIG_EXT:   trig_evt = ext_rise; // R03
            default:         trig_evt = 1'b0;
        endcase
    end

    // Next-state logic
    always_comb begin
        s_next          = s_reg;
        s_next.irq      = 1'b0;
        s_next.err      = 1'b0;
        s_next.ext_s    = {s_reg.ext_s[0], ext_trigger_pin};
        s_next.ext_prev = s_reg.ext_s[1];
        // Sequencer
        case (s_reg.state)
            ARRS_IDLE: begin
                if (s_reg.start)
                    s_next.state = ARRS_ARM;
            end
            ARRS_ARM: begin
                if (!s_reg.start)
                    s_next.state = ARRS_IDLE; // R04
                else if (trig_evt) begin
                    s_next.state = ARRS_CONV; // R03
                end
            end
            ARRS_CONV: begin
                if (conv_done) begin
                    s_next.res[s_reg.slot] = conv_result; // R05
                    s_next.slot = s_reg.slot + 3'h1; // R05 R10
                    s_next.irq  = s_reg.slot == ARRS_LAST_SLOT; // R06 R10
                end
                if (!s_reg.start) begin
                    s_next.state = ARRS_IDLE; // R04
                end
            end
            default: s_next.state = ARRS_IDLE;
        endcase
        // Register writes
        if (apb_wr) begin
            case (paddr)
                ARRS_CTRL_A_OFS: begin
                    s_next.start = pwdata[ARRS_START_BIT];
                    s_next.trig  = arrs_trig_t'(pwdata[ARRS_TRIG_LSB +: 2]);
                    if (pwdata[ARRS_START_BIT] && !s_reg.start)
                        s_next.slot = 3'h0; // R05
                end
                ARRS_CTRL_B_OFS: begin
                    s_next.stby  = pwdata[ARRS_STBY_BIT];
                    s_next.ext   = pwdata[ARRS_EXT_BIT];
                    s_next.res10 = pwdata[ARRS_RES10_BIT];
                end
                ARRS_INSEL_OFS: begin
                    s_next.chan = pwdata[ARRS_CH_LSB +: 3];
                    s_next.grp  = pwdata[ARRS_GRP_LSB +: 2];
                end
                default: s_next.err = !hit;
            endcase
        end
        // Read data captured in setup phase
        if (apb_rd) begin
            s_next.err = !hit;
            if (is_result(paddr))
                s_next.rdata = {22'h0, s_reg.res[paddr[4:2]]}; // R07
            else begin
                case (paddr)
                    ARRS_CTRL_A_OFS: s_next.rdata = {29'h0, s_reg.trig, s_reg.start};
                    ARRS_CTRL_B_OFS: s_next.rdata = {29'h0, s_reg.res10, s_reg.ext, s_reg.stby};
                    ARRS_INSEL_OFS:  s_next.rdata = {26'h0, s_reg.grp, 1'b0, s_reg.chan};
                    ARRS_STATUS_OFS: s_next.rdata = {27'h0, s_reg.slot, s_reg.state};
                    default:         s_next.rdata = ARRS_ZERO;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    // Outputs
    assign prdata      = s_reg.rdata;
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && (pwrite ? !hit : s_reg.err);
    assign conv_start  = s_reg.state == ARRS_CONV && s_reg.start; // R01
    assign input_sel   = sel;
    assign conv_res10  = s_reg.res10; // R01
    assign core_enable = s_reg.stby;
    assign conv_irq    = s_reg.irq;

    // Checks
    chk_irq_slot_wrap: assert property (@(posedge pclk) disable iff (!presetn) // R06
        (s_reg.state == ARRS_CONV && conv_done && s_reg.slot == ARRS_LAST_SLOT && s_reg.start)
        |=> conv_irq && s_reg.slot == 3'h0)
        else $error("irq not raised on slot 7 write");
    chk_irq_only_last: assert property (@(posedge pclk) disable iff (!presetn) // R06
        conv_irq |-> $past(s_reg.slot) == ARRS_LAST_SLOT && $past(conv_done))
        else $error("irq without slot 7 write");
    chk_slot_advance: assert property (@(posedge pclk) disable iff (!presetn) // R05
        (s_reg.state == ARRS_CONV && conv_done && !apb_wr)
        |=> s_reg.slot == $past(s_reg.slot) + 3'h1)
        else $error("slot did not advance");
    chk_result_store: assert property (@(posedge pclk) disable iff (!presetn) // R05
        (s_reg.state == ARRS_CONV && conv_done)
        |=> s_reg.res[$past(s_reg.slot)] == $past(conv_result))
        else $error("result not stored");
    chk_keeps_running: assert property (@(posedge pclk) disable iff (!presetn) // R04
        (s_reg.state == ARRS_CONV && s_reg.start) |=> s_reg.state == ARRS_CONV)
        else $error("conversion stopped without clear");
    chk_stop_on_clear: assert property (@(posedge pclk) disable iff (!presetn) // R04
        (s_reg.state != ARRS_IDLE && !s_reg.start) |=> s_reg.state == ARRS_IDLE && !conv_start)
        else $error("conversion did not stop");
    chk_sw_trigger: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (s_reg.state == ARRS_ARM && s_reg.start && s_reg.trig == ARRS_TRIG_SW)
        |=> s_reg.state == ARRS_CONV)
        else $error("software trigger ignored");
    chk_ref_select: assert property (@(posedge pclk) disable iff (!presetn) // R02
        s_reg.ext |-> input_sel == ARRS_REF_SEL)
        else $error("reference not selected");
    // Trigger, hold, stop, slot rewind, interrupt pulse and read-path checks
    chk_timer_trigger: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (s_reg.state == ARRS_ARM && s_reg.start && s_reg.trig == ARRS_TRIG_TIMER
            && timer_trigger_source) |=> s_reg.state == ARRS_CONV)
        else $error("timer trigger ignored");
    chk_ext_trigger: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (s_reg.state == ARRS_ARM && s_reg.start && s_reg.trig == ARRS_TRIG_EXT && ext_rise)
        |=> s_reg.state == ARRS_CONV)
        else $error("external trigger ignored");
    chk_wait_trigger: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (s_reg.state == ARRS_ARM && !trig_evt) |=> s_reg.state != ARRS_CONV)
        else $error("conversion began without trigger");
    chk_core_hold: assert property (@(posedge pclk) disable iff (!presetn) // R01
        (s_reg.state == ARRS_CONV && s_reg.start && !apb_wr) |=> conv_start)
        else $error("conversion paused while running");
    chk_start_stops: assert property (@(posedge pclk) disable iff (!presetn) // R04
        (apb_wr && paddr == ARRS_CTRL_A_OFS && !pwdata[ARRS_START_BIT]) |=> !conv_start)
        else $error("clearing start left conversion running");
    chk_rearm_slot: assert property (@(posedge pclk) disable iff (!presetn) // R05
        (apb_wr && paddr == ARRS_CTRL_A_OFS && pwdata[ARRS_START_BIT] && !s_reg.start)
        |=> s_reg.slot == 3'h0)
        else $error("slot not rewound on start");
    chk_irq_one_pulse: assert property (@(posedge pclk) disable iff (!presetn) // R06 R10
        conv_irq |=> !conv_irq)
        else $error("irq held longer than one cycle");
    chk_read_result: assert property (@(posedge pclk) disable iff (!presetn) // R07
        (apb_rd && is_result(paddr)) |=> prdata == {22'h0, $past(s_reg.res[paddr[4:2]])})
        else $error("result read returned wrong slot");
endmodule
`default_nettype wire

/* verif/arrs_core_model.sv */
// Behavioural conversion core for the sequencer bench
`default_nettype none
module arrs_core_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Sequencer side
    input  wire logic       conv_start,
    input  wire logic       core_enable,
    output logic            conv_done,
    output logic      [9:0] conv_result
);
    timeunit 1ns;
    timeprecision 1ns;
    int   seed = 32'h1D35;
    int   wait_cnt;
    logic pend;
    // Result offered only while running and powered
    assign conv_done = pend && conv_start && core_enable;
    // Latency of 0 to 3 cycles; value inverted once taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= 1'b0;
            wait_cnt <= 0;
            conv_result <= 10'h000;
        end else if (conv_done) begin
            pend <= 1'b0;
            wait_cnt <= {$random(seed)} % 4;
            conv_result <= ~conv_result;
        end else if (!pend && wait_cnt == 0) begin
            pend <= 1'b1;
            conv_result <= 10'($random(seed));
        end else if (!pend) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule
`default_nettype wire

/* verif/arrs_seq_tb.sv */
// Self-checking bench for the repeat-ring sequencer
`default_nettype none
module arrs_seq_tb;
    import arrs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sl;
    logic        timer_trigger_source, ext_trigger_pin, conv_start, conv_res10;
    logic        core_enable, conv_done, conv_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  input_sel;
    logic [9:0]  conv_result;
    logic [9:0]  exp_q [8];
    int          err_count, tests_run, cnt, irqs, seed;
    arrs_seq arrs_seq_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .timer_trigger_source, .ext_trigger_pin,
        .conv_start, .input_sel, .conv_res10, .core_enable, .conv_done, .conv_result,
        .conv_irq);
    arrs_core_model arrs_core_model_i (.pclk, .presetn, .conv_start, .core_enable,
        .conv_done, .conv_result);
    // Clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Reference model: slot rotation and interrupt count
    always @(posedge pclk) begin
        if (conv_done === 1'b1) begin
            exp_q[cnt % 8] = conv_result;
            cnt++;
        end
        if (conv_irq === 1'b1) irqs++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            wrap_up();
        end
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Run with one trigger source for n results, stop, collect
    task automatic run(input logic [1:0] trig, input int n);
        cnt = 0;
        irqs = 0;
        apb(1'b1, ARRS_CTRL_A_OFS, {29'h0, trig, 1'b1});
        repeat (4) @(posedge pclk);
        chk(conv_start, trig == ARRS_TRIG_SW);
        timer_trigger_source <= (trig == ARRS_TRIG_TIMER);
        ext_trigger_pin <= (trig == ARRS_TRIG_EXT);
        @(posedge pclk);
        timer_trigger_source <= 1'b0;
        for (int k = 0; k < 3000 && cnt < n; k++) @(posedge pclk);
        if (cnt < n) begin
            err_count++;
            wrap_up();
        end
        chk(conv_start, 1'b1);
        apb(1'b1, ARRS_CTRL_A_OFS, ARRS_ZERO);
        ext_trigger_pin <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(conv_start, 1'b0);
        chk(irqs, cnt / 8);
        for (int i = 0; i < ARRS_NUM_RES; i++) begin
            apb(1'b0, ARRS_RESULT_OFS + 12'(4 * i), ARRS_ZERO);
            chk(rd, {22'h0, exp_q[i]});
        end
        $display("Run with trigger %0d done, %0d results", trig, cnt);
    endtask
    // Main sequence
    initial begin
        seed = 32'h5fce;
        {presetn, psel, penable, pwrite, timer_trigger_source, ext_trigger_pin} = '0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ARRS_STATUS_OFS, ARRS_ZERO);
        chk(rd, ARRS_ZERO);
        chk(sl, 1'b0);
        for (int i = 0; i < 12; i++) begin
            apb(1'b1, ARRS_INSEL_OFS, 32'((i / 4) << 4 | i % 4));
            chk(input_sel, i);
        end
        apb(1'b1, ARRS_CTRL_B_OFS, 32'h0000_0003);
        chk(input_sel, ARRS_REF_SEL);
        chk(conv_res10, 1'b0);
        apb(1'b1, ARRS_CTRL_B_OFS, 32'h0000_0005);
        chk(conv_res10, 1'b1);
        chk(core_enable, 1'b1);
        $display("Selection test done");
        run(ARRS_TRIG_SW, 17 + {$random(seed)} % 8);
        run(ARRS_TRIG_TIMER, 8 + {$random(seed)} % 8);
        run(ARRS_TRIG_EXT, 9 + {$random(seed)} % 20);
        apb(1'b1, ARRS_RESULT_OFS, 32'h0000_03FF);
        chk(sl, 1'b0);
        apb(1'b0, ARRS_RESULT_OFS, ARRS_ZERO);
        chk(rd, {22'h0, exp_q[0]});
        apb(1'b0, 12'h100, ARRS_ZERO);
        chk(sl, 1'b1);
        chk(rd, ARRS_ZERO);
        $display("Access test done");
        wrap_up();
    end
endmodule
`default_nettype wire
